// file: bench/cpurf_top_assertions.sv
// Checker on the top ports of the core register file.
// Assumes one clock domain and binding onto cpurf_top.
`timescale 1ns/1ps
`default_nettype none
module cpurf_checker (
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst_n,
	// Core side
	input wire logic                   coreWrEn,
	input wire cpurf_pkg::cpurf_id_t   coreRdSel,
	input wire cpurf_pkg::cpurf_word_t coreRdData,
	input wire logic                   hwIntAccept,
	input wire logic                   swIntExec,
	input wire logic [7:0]             swIntNum,
	input wire cpurf_pkg::cpurf_word_t staticBase,
	input wire cpurf_pkg::cpurf_word_t programCounter,
	input wire cpurf_pkg::cpurf_word_t stackPointer,
	input wire cpurf_pkg::cpurf_word_t processorFlags,
	// Wishbone
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_we_i,
	input wire logic [7:0]             wb_adr_i,
	input wire logic                   wb_ack_o,
	input wire cpurf_pkg::cpurf_word_t wb_dat_o
);
	import cpurf_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==============================================================
	// Bus handshake
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_no_spurious_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[7:6] != 2'b00
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	// ==============================================================
	// Stack flag, bases, reset
	a_hw_clear: assert property (hwIntAccept |=> !processorFlags[7])
		else $error("hardware interrupt left stack flag set");
	a_sw_clear: assert property (swIntExec && !swIntNum[7] |=> !processorFlags[7])
		else $error("low software interrupt left stack flag set");
	a_sw_high_keeps: assert property (swIntExec && swIntNum[7] && !hwIntAccept && !coreWrEn && !wb_ack_o
		|=> $stable(processorFlags)) else $error("high software interrupt changed flags");
	a_bases_hold: assert property (!coreWrEn && !wb_ack_o |=> $stable(staticBase) && $stable(programCounter))
		else $error("base changed without write");
	a_rd_pc: assert property (coreRdSel == 5'h1a |=> coreRdData == $past(programCounter))
		else $error("core read of program counter wrong");
	a_reset_clean: assert property ($rose(rst_n) |-> processorFlags == 32'h0 && stackPointer == 32'h0
		&& !wb_ack_o) else $error("state not cleared by reset");
endmodule : cpurf_checker

bind cpurf_top cpurf_checker u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .coreWrEn(coreWrEn), .coreRdSel(coreRdSel),
	.coreRdData(coreRdData), .hwIntAccept(hwIntAccept), .swIntExec(swIntExec), .swIntNum(swIntNum),
	.staticBase(staticBase), .programCounter(programCounter), .stackPointer(stackPointer),
	.processorFlags(processorFlags), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o)
);
`default_nettype wire

// file: bench/cpurf_top_tb.sv
// Self-checking bench for the core register file.
// Assumes the checker is bound separately; bench drives all ports.
`timescale 1ns/1ps
`default_nettype none
module cpurf_top_tb;
	import cpurf_pkg::*;
	logic        core_clk, rst_n, coreWrEn, hwIntAccept, swIntExec, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	cpurf_id_t   coreWrSel, coreRdSel;
	cpurf_word_t coreWrData, coreRdData, addrBase, staticBase, frameBase, programCounter, rd;
	cpurf_word_t vectorTableBase, stackPointer, processorFlags, wb_dat_i, wb_dat_o;
	logic [1:0]  coreBaseSel;
	logic [7:0]  swIntNum, wb_adr_i;
	logic [3:0]  wb_sel_i;
	int          failures, samplesChecked;

	cpurf_top i_dut (
		.core_clk(core_clk), .rst_n(rst_n), .coreWrEn(coreWrEn), .coreWrSel(coreWrSel),
		.coreWrData(coreWrData), .coreRdSel(coreRdSel), .coreRdData(coreRdData), .coreBaseSel(coreBaseSel),
		.addrBase(addrBase), .hwIntAccept(hwIntAccept), .swIntExec(swIntExec), .swIntNum(swIntNum),
		.staticBase(staticBase), .frameBase(frameBase), .programCounter(programCounter),
		.vectorTableBase(vectorTableBase), .stackPointer(stackPointer), .processorFlags(processorFlags),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ==============================================================
	// Shared tasks
	task automatic wrap_up();
		if (failures == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input cpurf_word_t seen, input cpurf_word_t exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Held until ack is sampled; the bound cuts a hung slave short
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input cpurf_word_t dat);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			wrap_up();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : bus

	task automatic bread(input logic [7:0] adr, input string nm, input cpurf_word_t exp);
		bus(1'b0, adr, 4'hf, 32'h0);
		chk(nm, rd, exp);
	endtask : bread

	task automatic cwr(input cpurf_id_t sel, input cpurf_word_t dat);
		@(posedge core_clk);
		coreWrEn   <= 1'b1;
		coreWrSel  <= sel;
		coreWrData <= dat;
		@(posedge core_clk);
		coreWrEn <= 1'b0;
	endtask : cwr

	task automatic crd(input cpurf_id_t sel, input string nm, input cpurf_word_t exp);
		@(posedge core_clk);
		coreRdSel <= sel;
		repeat (2) @(posedge core_clk);
		chk(nm, coreRdData, exp);
	endtask : crd

	// ==============================================================
	// Scenarios
	task automatic t_halves_bytes();
		for (int p = 0; p < 4; p++) begin
			cwr(5'(4 + 2 * p), 32'h1000 + 32'(p));
			cwr(5'(5 + 2 * p), 32'h2000 + 32'(p));
			bread(8'(4 * p), "pair halves", {16'h2000 + 16'(p), 16'h1000 + 16'(p)});
			crd(5'(5 + 2 * p), "high half", 32'h2000 + 32'(p));
		end
		cwr(5'h01, 32'h11223344);
		cwr(5'h11, 32'h00000055);
		bread(8'h04, "byte merge", 32'h11553344);
		for (int i = 0; i < 4; i++) cwr(5'(5'h0c + i), 32'hc0 + 32'(i));
		bread(8'h00, "byte order", 32'hc0c1c2c3);
		crd(5'h0e, "mid-lower byte", 32'h000000c2);
	endtask : t_halves_bytes

	task automatic t_bases();
		// Word-aligned values, so stack pointers stay multiples of four
		for (int i = 0; i < 10; i++) cwr(5'(5'h14 + i), 32'h0a000000 + 32'(4 * i));
		for (int i = 0; i < 10; i++) bread(8'(8'h10 + 4 * i), "base word", 32'h0a000000 + 32'(4 * i));
		chk("static base", staticBase, 32'h0a000010);
		chk("frame base", frameBase, 32'h0a000014);
		chk("program counter", programCounter, 32'h0a000018);
		chk("vector base", vectorTableBase, 32'h0a00001c);
		chk("interrupt sp active", stackPointer, 32'h0a000024);
		crd(5'h1a, "program counter read", 32'h0a000018);
		coreBaseSel <= 2'h2;
		repeat (2) @(posedge core_clk);
		chk("address base", addrBase, 32'h0a000008);
		bus(1'b1, 8'h20, 4'b0101, 32'hffffffff);
		crd(5'h18, "static lanes", 32'h0aff00ff);
	endtask : t_bases

	task automatic t_stack_irq();
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 8'h3c, 4'h1, 32'h00000080);
			repeat (2) @(posedge core_clk);
			chk("user sp", stackPointer, 32'h0a000020);
			crd(5'h1e, "active sp", 32'h0a000020);
			hwIntAccept <= (i == 0);
			swIntExec   <= (i != 0);
			swIntNum    <= (i == 1) ? 8'h7f : 8'h80;
			@(posedge core_clk);
			hwIntAccept <= 1'b0;
			swIntExec   <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk("stack flag", {31'h0, processorFlags[7]}, {31'h0, i == 2});
			bread(8'h38, "sp alias", (i == 2) ? 32'h0a000020 : 32'h0a000024);
		end
	endtask : t_stack_irq

	task automatic t_bank();
		bus(1'b1, 8'h3c, 4'hf, 32'h00000010);
		cwr(5'h14, 32'h000000b1);
		bread(8'h10, "bank one addr", 32'h000000b1);
		bus(1'b1, 8'h3c, 4'hf, 32'h0);
		bread(8'h10, "bank zero addr", 32'h0a000000);
		crd(5'h00, "bank zero data", 32'hc0c1c2c3);
	endtask : t_bank

	task automatic t_unmapped_reset();
		bus(1'b1, 8'h40, 4'hf, 32'hdeadbeef);
		bread(8'h40, "unmapped read", 32'h0);
		bread(8'h00, "mapped kept", 32'hc0c1c2c3);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		bread(8'h28, "program counter after reset", 32'h0);
		chk("flags after reset", processorFlags, 32'h0);
	endtask : t_unmapped_reset

	task automatic t_reset_values();
		for (int a = 0; a < 64; a += 4) bread(8'(a), "reset word", 32'h0);
	endtask : t_reset_values

	initial begin
		failures = 0;
		samplesChecked = 0;
		{rst_n, coreWrEn, hwIntAccept, swIntExec, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
		{coreWrSel, coreRdSel, coreBaseSel, swIntNum, wb_adr_i, wb_sel_i} = '0;
		{coreWrData, wb_dat_i} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset_values();
		t_halves_bytes();
		t_bases();
		t_stack_irq();
		t_bank();
		t_unmapped_reset();
		wrap_up();
	end
endmodule : cpurf_top_tb
`default_nettype wire

// file: src/cpurf_consts.svh
// Constants of the core register file: offsets, field positions, resets.
// Assumes inclusion by bare name from the files of this block only.
`ifndef CPURF_CONSTS_SVH
`define CPURF_CONSTS_SVH

// ==============================================================
// Bus offsets (byte addresses, one aligned word each)
`define CPURF_OFS_DATA_A     8'h00
`define CPURF_OFS_DATA_B     8'h04
`define CPURF_OFS_DATA_C     8'h08
`define CPURF_OFS_DATA_D     8'h0c
`define CPURF_OFS_ADDR_0     8'h10
`define CPURF_OFS_ADDR_1     8'h14
`define CPURF_OFS_ADDR_2     8'h18
`define CPURF_OFS_ADDR_3     8'h1c
`define CPURF_OFS_STATIC     8'h20
`define CPURF_OFS_FRAME      8'h24
`define CPURF_OFS_PROG_CNT   8'h28
`define CPURF_OFS_VECTOR     8'h2c
`define CPURF_OFS_USER_SP    8'h30
`define CPURF_OFS_INTR_SP    8'h34
`define CPURF_OFS_ACTIVE_SP  8'h38
`define CPURF_OFS_FLAGS      8'h3c

// ==============================================================
// Flag fields and reset values
`define CPURF_FLAG_STACK_SEL 7
`define CPURF_FLAG_BANK_SEL  4
`define CPURF_FLAG_RESET     32'h00000000
`define CPURF_WORD_RESET     32'h00000000
`define CPURF_BYTE_RESET     8'h00

// ==============================================================
// Core selector codes and physical slots
`define CPURF_ID_HALF_BASE   5'h04
`define CPURF_ID_BYTE_BASE   5'h0c
`define CPURF_ID_WORD2_BASE  5'h14
`define CPURF_ID_WORD2_OFS   5'h10
`define CPURF_PHYS_BANKED    5'h08
`define CPURF_PHYS_FLAGS     5'h16
`define CPURF_PHYS_USER_SP   5'h14
`define CPURF_PHYS_INTR_SP   5'h15
`define CPURF_PHYS_STATIC    5'h10
`define CPURF_PHYS_FRAME     5'h11
`define CPURF_PHYS_PROG_CNT  5'h12
`define CPURF_PHYS_VECTOR    5'h13
`define CPURF_PHYS_COUNT     22

`endif

// file: src/cpurf_pkg.sv
// Types shared by the core register file modules.
// Assumes nothing beyond a SystemVerilog compiler.
package cpurf_pkg;

	// ==============================================================
	// Plain types
	typedef logic [31:0] cpurf_word_t;
	typedef logic [4:0]  cpurf_id_t;
	typedef logic [4:0]  cpurf_phys_t;

	// ==============================================================
	// Logical registers, in bus word order
	typedef enum logic [3:0] {
		LR_DATA_A    = 4'h0,
		LR_DATA_B    = 4'h1,
		LR_DATA_C    = 4'h2,
		LR_DATA_D    = 4'h3,
		LR_ADDR_0    = 4'h4,
		LR_ADDR_1    = 4'h5,
		LR_ADDR_2    = 4'h6,
		LR_ADDR_3    = 4'h7,
		LR_STATIC    = 4'h8,
		LR_FRAME     = 4'h9,
		LR_PROG_CNT  = 4'ha,
		LR_VECTOR    = 4'hb,
		LR_USER_SP   = 4'hc,
		LR_INTR_SP   = 4'hd,
		LR_ACTIVE_SP = 4'he,
		LR_FLAGS     = 4'hf
	} cpurf_lreg_e;

	typedef struct packed {
		cpurf_lreg_e lreg;
		logic [3:0]  be;
		logic [1:0]  lane;
	} cpurf_sel_s;

endpackage : cpurf_pkg

// file: src/cpurf_top.sv
// Core register file: banked data and address registers, bases,
// program counter, vector base, two stack pointers and the flag word.
// Assumes core ports are driven by logic on core_clk; Wishbone same clock.
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_consts.svh"
module cpurf_top (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// Core write port
	input  wire logic                   coreWrEn,
	input  wire cpurf_pkg::cpurf_id_t   coreWrSel,
	input  wire cpurf_pkg::cpurf_word_t coreWrData,
	// Core read port
	input  wire cpurf_pkg::cpurf_id_t   coreRdSel,
	output var  cpurf_pkg::cpurf_word_t coreRdData,
	// Address register base port
	input  wire logic [1:0]             coreBaseSel,
	output var  cpurf_pkg::cpurf_word_t addrBase,
	// Interrupt events
	input  wire logic                   hwIntAccept,
	input  wire logic                   swIntExec,
	input  wire logic [7:0]             swIntNum,
	// Addressing bases and state
	output var  cpurf_pkg::cpurf_word_t staticBase,
	output var  cpurf_pkg::cpurf_word_t frameBase,
	output var  cpurf_pkg::cpurf_word_t programCounter,
	output var  cpurf_pkg::cpurf_word_t vectorTableBase,
	output var  cpurf_pkg::cpurf_word_t stackPointer,
	output var  cpurf_pkg::cpurf_word_t processorFlags,
	// Wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire cpurf_pkg::cpurf_word_t wb_dat_i,
	output var  logic                   wb_ack_o,
	output var  cpurf_pkg::cpurf_word_t wb_dat_o
);
	import cpurf_pkg::*;

	// ==============================================================
	// Selector decode
	// Codes 00-03 words, 04-0b halves, 0c-13 bytes, 14-1f others.
	function automatic cpurf_sel_s decodeSel(input cpurf_id_t id);
		cpurf_sel_s s;
		cpurf_id_t  k;
		s = '{lreg: LR_DATA_A, be: 4'hf, lane: 2'h0};
		k = 5'h00;
		if (id < `CPURF_ID_HALF_BASE) begin
			s.lreg = cpurf_lreg_e'({2'b00, id[1:0]});
		end else if (id < `CPURF_ID_BYTE_BASE) begin
			k      = 5'(id - `CPURF_ID_HALF_BASE);
			s.lreg = cpurf_lreg_e'({2'b00, k[2:1]});
			s.be   = k[0] ? 4'hc : 4'h3;
			s.lane = k[0] ? 2'h2 : 2'h0;
		end else if (id < `CPURF_ID_WORD2_BASE) begin
			// Byte order runs upper, mid-upper, mid-lower, lower
			k      = 5'(id - `CPURF_ID_BYTE_BASE);
			s.lreg = cpurf_lreg_e'({3'b000, k[2]});
			s.lane = 2'(2'h3 - k[1:0]);
			s.be   = 4'(4'h1 << s.lane);
		end else begin
			s.lreg = cpurf_lreg_e'(4'(id - `CPURF_ID_WORD2_OFS));
		end
		return s;
	endfunction : decodeSel

	// ==============================================================
	// Logical to physical slot
	// Slots 0-7 bank 0, 8-15 bank 1, then unbanked words, then flags.
	function automatic cpurf_phys_t physOf(input cpurf_lreg_e lreg,
	                                      input logic bank,
	                                      input logic userSp);
		cpurf_phys_t p;
		p = `CPURF_PHYS_FLAGS;
		if (lreg < LR_STATIC)
			p = {1'b0, bank, lreg[2:0]};
		else if (lreg == LR_ACTIVE_SP)
			p = userSp ? `CPURF_PHYS_USER_SP : `CPURF_PHYS_INTR_SP;
		else if (lreg != LR_FLAGS)
			p = 5'({1'b0, lreg} + `CPURF_PHYS_BANKED);
		return p;
	endfunction : physOf

	// ==============================================================
	// Flag word fields
	cpurf_word_t flags_ff;
	wire         bankSel = flags_ff[`CPURF_FLAG_BANK_SEL];
	wire         userSp  = flags_ff[`CPURF_FLAG_STACK_SEL];

	// ==============================================================
	// Core write decode
	cpurf_sel_s  coreWrDec;
	cpurf_phys_t coreWrPhys;
	cpurf_word_t coreWrWord;
	logic [3:0]  coreWrBe;
	assign coreWrDec  = decodeSel(coreWrSel);
	assign coreWrPhys = physOf(coreWrDec.lreg, bankSel, userSp);
	// Sub-register data moves to its lane; other lanes untouched
	assign coreWrWord = 32'(coreWrData << {coreWrDec.lane, 3'b000});
	assign coreWrBe   = coreWrEn ? coreWrDec.be : 4'h0;

	// ==============================================================
	// Bus decode
	wire         wbWrStrobe;
	wire         wbMapped = wb_adr_i[7:6] == 2'b00;
	cpurf_lreg_e wbLreg;
	cpurf_phys_t wbPhys;
	logic [3:0]  wbBe;
	assign wbLreg = cpurf_lreg_e'(wb_adr_i[5:2]);
	assign wbPhys = physOf(wbLreg, bankSel, userSp);
	// Unmapped writes are dropped
	assign wbBe   = (wbWrStrobe && wbMapped) ? wb_sel_i : 4'h0;

	// ==============================================================
	// Word register slots
	cpurf_word_t wordQ [`CPURF_PHYS_COUNT];
	genvar i;
	generate
		for (i = 0; i < `CPURF_PHYS_COUNT; i = i + 1) begin : g_slot
			wire [3:0] slotCoreBe = (coreWrPhys == 5'(i)) ? coreWrBe : 4'h0;
			wire [3:0] slotBusBe  = (wbPhys == 5'(i)) ? wbBe : 4'h0;
			// Core wins a byte that both ports write in one cycle
			cpurf_word_reg u_word (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.aBe      (slotCoreBe),
				.aData    (coreWrWord),
				.bBe      (slotBusBe),
				.bData    (wb_dat_i),
				.q        (wordQ[i])
			);
		end
	endgenerate

	// ==============================================================
	// Flag register
	// Interrupt clear of the stack flag beats a same-cycle write.
	wire [3:0]   flagCoreBe = (coreWrPhys == `CPURF_PHYS_FLAGS) ? coreWrBe : 4'h0;
	wire [3:0]   flagBusBe  = (wbPhys == `CPURF_PHYS_FLAGS) ? wbBe : 4'h0;
	wire         swIntLow   = swIntExec && !swIntNum[7];
	wire         stackClr   = hwIntAccept || swIntLow;
	cpurf_word_t flagMerged;
	cpurf_word_t nxt_flags;
	genvar fb;
	generate
		for (fb = 0; fb < 4; fb = fb + 1) begin : g_flag
			assign flagMerged[8*fb +: 8] = flagCoreBe[fb] ? coreWrWord[8*fb +: 8] :
			                               flagBusBe[fb]  ? wb_dat_i[8*fb +: 8] :
			                               flags_ff[8*fb +: 8];
		end
	endgenerate
	always_comb begin
		nxt_flags = flagMerged;
		if (stackClr)
			nxt_flags[`CPURF_FLAG_STACK_SEL] = 1'b0;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			flags_ff <= `CPURF_FLAG_RESET;
		else
			flags_ff <= nxt_flags;
	end

	// ==============================================================
	// Read selection
	function automatic cpurf_word_t slotValue(input cpurf_phys_t p,
	                                         input cpurf_word_t flagWord,
	                                         input cpurf_word_t w [`CPURF_PHYS_COUNT]);
		cpurf_word_t v;
		v = flagWord;
		if (p != `CPURF_PHYS_FLAGS)
			v = w[p];
		return v;
	endfunction : slotValue

	cpurf_sel_s  coreRdDec;
	cpurf_phys_t coreRdPhys;
	cpurf_word_t coreRdWord;
	cpurf_word_t coreRdShift;
	cpurf_word_t coreRdMask;
	cpurf_word_t nxt_coreRd;
	assign coreRdDec   = decodeSel(coreRdSel);
	assign coreRdPhys  = physOf(coreRdDec.lreg, bankSel, userSp);
	assign coreRdWord  = slotValue(coreRdPhys, flags_ff, wordQ);
	assign coreRdShift = coreRdWord >> {coreRdDec.lane, 3'b000};
	// Halves and bytes read right-aligned, zero-extended
	assign coreRdMask  = (coreRdDec.be == 4'hf) ? 32'hffffffff :
	                     (coreRdDec.be == 4'h3 || coreRdDec.be == 4'hc) ? 32'h0000ffff :
	                     32'h000000ff;
	assign nxt_coreRd  = coreRdShift & coreRdMask;

	cpurf_word_t wbRdWord;
	assign wbRdWord = wbMapped ? slotValue(wbPhys, flags_ff, wordQ) : `CPURF_WORD_RESET;

	// Address register base, from the active bank
	wire cpurf_phys_t basePhys = {1'b0, bankSel, 1'b1, coreBaseSel};

	// ==============================================================
	// Registered core outputs
	// Stack pointer low bits kept as written; alignment is software's
	cpurf_word_t coreRd_ff;
	cpurf_word_t addrBase_ff;
	cpurf_word_t stack_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			coreRd_ff   <= `CPURF_WORD_RESET;
			addrBase_ff <= `CPURF_WORD_RESET;
			stack_ff    <= `CPURF_WORD_RESET;
		end else begin
			coreRd_ff   <= nxt_coreRd;
			addrBase_ff <= wordQ[basePhys];
			stack_ff    <= nxt_flags[`CPURF_FLAG_STACK_SEL] ?
			               wordQ[`CPURF_PHYS_USER_SP] : wordQ[`CPURF_PHYS_INTR_SP];
		end
	end

	assign coreRdData      = coreRd_ff;
	assign addrBase        = addrBase_ff;
	assign stackPointer    = stack_ff;
	assign staticBase      = wordQ[`CPURF_PHYS_STATIC];
	assign frameBase       = wordQ[`CPURF_PHYS_FRAME];
	assign programCounter  = wordQ[`CPURF_PHYS_PROG_CNT];
	assign vectorTableBase = wordQ[`CPURF_PHYS_VECTOR];
	assign processorFlags  = flags_ff;

	// ==============================================================
	// Bus slave
	cpurf_wb_slave u_wb (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.rdWord   (wbRdWord),
		.wb_ack_o (wb_ack_o),
		.wb_dat_o (wb_dat_o),
		.wrStrobe (wbWrStrobe)
	);

endmodule : cpurf_top
`default_nettype wire

// file: src/cpurf_wb_slave.sv
// Classic Wishbone slave handshake for the register file.
// Assumes a single-clock master that holds the request until ack.
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_consts.svh"
module cpurf_wb_slave (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Wishbone request
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	// Read data from the register mux
	input  wire cpurf_pkg::cpurf_word_t rdWord,
	// Wishbone answer
	output var  logic              wb_ack_o,
	output var  cpurf_pkg::cpurf_word_t wb_dat_o,
	// Write strobe, high in the ack cycle
	output var  logic              wrStrobe
);
	import cpurf_pkg::*;

	logic        ack_ff;
	cpurf_word_t dat_ff;
	wire         request = wb_cyc_i && wb_stb_i;
	wire         nxt_ack = request && !ack_ff;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			dat_ff <= `CPURF_WORD_RESET;
		end else begin
			ack_ff <= nxt_ack;
			if (nxt_ack && !wb_we_i)
				dat_ff <= rdWord;
		end
	end

	// Write lands on the edge where the master sees ack
	assign wrStrobe = request && wb_we_i && ack_ff;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

endmodule : cpurf_wb_slave
`default_nettype wire

// file: src/cpurf_word_reg.sv
// One 32-bit register with two byte-enabled write ports.
// Assumes port A has priority over port B on a shared byte.
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_consts.svh"
module cpurf_word_reg (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Write port A (core)
	input  wire logic [3:0]        aBe,
	input  wire cpurf_pkg::cpurf_word_t aData,
	// Write port B (bus)
	input  wire logic [3:0]        bBe,
	input  wire cpurf_pkg::cpurf_word_t bData,
	// Stored value
	output var  cpurf_pkg::cpurf_word_t q
);
	import cpurf_pkg::*;

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_byte
			logic [7:0] byte_ff;
			wire  [7:0] nxt_byte = aBe[b] ? aData[8*b +: 8] : bData[8*b +: 8];
			// Untouched bytes hold, so partial writes merge
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					byte_ff <= `CPURF_BYTE_RESET;
				else if (aBe[b] || bBe[b])
					byte_ff <= nxt_byte;
			end
			assign q[8*b +: 8] = byte_ff;
		end
	endgenerate

endmodule : cpurf_word_reg
`default_nettype wire
